/* File: subf_pkg.sv */
/*
 * Constants and types for the subtract-from datapath: instruction field
 * positions, opcodes, register map, flag and status bit positions.
 * Assumes instruction bit 0 (big-endian numbering) is bit 31 of the word.
 */
package subf_pkg;

	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 4;
	localparam int          STATUS_W    = 3;
	localparam int          FLAGS_W     = 3;
	localparam int          CR_W        = 4;
	localparam int          FIELD_W     = 5;
	localparam int          IMM_W       = 16;

	// Instruction field positions (little-endian view of the word)
	localparam int          OPC_HI      = 31;
	localparam int          OPC_LO      = 26;
	localparam int          TGT_HI      = 25;
	localparam int          TGT_LO      = 21;
	localparam int          OE_POS      = 10;
	localparam int          XO_HI       = 9;
	localparam int          XO_LO       = 1;
	localparam int          REC_POS     = 0;
	localparam int          IMM_HI      = 15;
	localparam int          IMM_LO      = 0;

	localparam logic [5:0]  PRIMARY_EXT = 6'h1f;
	localparam logic [5:0]  PRIMARY_IMM = 6'h08;
	localparam logic [8:0]  XO_EXT      = 9'h088;
	localparam logic [8:0]  XO_MINUS    = 9'h0e8;
	localparam logic [31:0] ALL_ONES    = 32'hffffffff;
	localparam logic [15:0] IMM_MINUS1  = 16'hffff;

	// Register map
	localparam logic [3:0]  FLAGS_ADDR  = 4'h0;
	localparam logic [3:0]  STATUS_ADDR = 4'h4;
	localparam logic [3:0]  MASK_ADDR   = 4'h8;
	localparam logic [3:0]  RESULT_ADDR = 4'hc;

	localparam int          FLAG_CARRY  = 0;
	localparam int          FLAG_OVF    = 1;
	localparam int          FLAG_SO     = 2;

	localparam int          EV_OVF      = 0;
	localparam int          EV_DONE     = 1;
	localparam int          EV_ILLEGAL  = 2;

	localparam int          CR_NEG      = 3;
	localparam int          CR_POS      = 2;
	localparam int          CR_ZERO     = 1;
	localparam int          CR_SO       = 0;

	localparam logic [2:0]  STATUS_RST  = 3'h0;
	localparam logic [2:0]  MASK_RST    = 3'h0;
	localparam logic [3:0]  CR_RST      = 4'h0;
	localparam logic [4:0]  FIELD_RST   = 5'h00;
	localparam logic [31:0] WORD_RST    = 32'h00000000;

	typedef enum logic [3:0] {
		OP_NONE  = 4'h1,
		OP_EXT   = 4'h2,
		OP_IMM   = 4'h4,
		OP_MINUS = 4'h8
	} op_t;

endpackage : subf_pkg

/* File: subtract_from_carry_datapath.sv */
/*
 * Single-cycle subtract-from datapath: extended, immediate carrying and
 * minus-one extended forms, with carry/overflow/summary-overflow flags,
 * condition field zero, a small register port and one interrupt.
 * Assumes the decoder presents an instruction with both source register
 * values in the same cycle, all on clk; results appear one cycle later.
 */
//
// Function
// - Extended subtract adds inverted first source, second source and carry into the target.
// - Immediate carrying subtract adds inverted source, one and the sign-extended immediate.
// - Immediate carrying subtract decodes from primary opcode 08 with target, source, imm16.
// - An immediate of minus one yields exactly the inverse of the source register.
// - Immediate carrying subtract has one form and never touches condition field zero.
// - Immediate carrying subtract always updates the carry flag from its carry out.
// - Minus-one extended subtract adds inverted source, carry and the all-ones word.
// - Minus-one extended subtract decodes from opcode 31, extended 232, OE at 21, record at 31.
// - Every minus-one extended form updates the carry flag regardless of OE and record.
// - With OE set, overflow and summary overflow are updated as well.
// - With record set, condition field zero gets negative, positive, zero and summary overflow.
// - Both mnemonic sets are the same hardware; four forms differ only in flags written.
// - Overflow and sign indications treat operands and results as 32-bit signed values.
// - Extended subtract decodes from opcode 31, extended 136, same OE and record positions.
`timescale 1ns/1ps

module subtract_from_carry_datapath
	import subf_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                instr_valid,
	input  wire logic [DATA_W-1:0]   instr,
	input  wire logic [DATA_W-1:0]   first_source_value,
	input  wire logic [DATA_W-1:0]   second_source_value,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DATA_W-1:0]   reg_rdata_ff,
	output logic      [DATA_W-1:0]   result_ff,
	output logic      [FIELD_W-1:0]  target_register_field_ff,
	output logic                     result_write_ff,
	output logic      [CR_W-1:0]     cr0_ff,
	output logic                     cr0_write_ff,
	output logic                     carry_flag_ff,
	output logic                     overflow_flag_ff,
	output logic                     summary_overflow_ff,
	output logic                     irq_ff
);

	op_t                   op;
	logic [5:0]            opcode;
	logic [8:0]            ext_opcode;
	logic [IMM_W-1:0]      imm;
	logic [DATA_W-1:0]     inv_a;
	logic [DATA_W-1:0]     addend;
	logic                  carry_in;
	logic [DATA_W:0]       sum;
	logic [DATA_W-1:0]     sum_word;
	logic                  carry_out;
	logic                  ovf;
	logic                  is_x_form;
	logic                  oe_form;
	logic                  record_bit;
	logic                  exec;
	logic                  illegal;
	logic                  flags_wr;
	logic                  status_wr;
	logic                  mask_wr;
	logic                  cur_so;
	logic                  nxt_so;
	logic [STATUS_W-1:0]   status_ff;
	logic [STATUS_W-1:0]   mask_ff;
	logic [STATUS_W-1:0]   events;
	logic [STATUS_W-1:0]   nxt_status;

	assign opcode     = instr[OPC_HI:OPC_LO];
	assign ext_opcode = instr[XO_HI:XO_LO];
	assign imm        = instr[IMM_HI:IMM_LO];

	// Decode; the two mnemonic families carry identical encodings, so one path serves both
	always_comb begin
		op = OP_NONE;
		if (instr_valid) begin
			if (opcode == PRIMARY_IMM) begin
				op = OP_IMM;
			end else if (opcode == PRIMARY_EXT && ext_opcode == XO_EXT) begin
				op = OP_EXT;
			end else if (opcode == PRIMARY_EXT && ext_opcode == XO_MINUS) begin
				op = OP_MINUS;
			end
		end
	end

	assign exec      = (op != OP_NONE);
	assign illegal   = instr_valid && (op == OP_NONE);
	assign is_x_form = (op == OP_EXT) || (op == OP_MINUS);
	// Immediate form has no OE or record bit: its low half is the immediate
	assign oe_form    = is_x_form && instr[OE_POS];
	assign record_bit = is_x_form && instr[REC_POS];

	// Operand select feeding one shared adder
	assign inv_a = ~first_source_value;
	always_comb begin
		case (op)
			OP_EXT: begin
				addend   = second_source_value;
				carry_in = carry_flag_ff;
			end
			OP_IMM: begin
				addend   = {{(DATA_W-IMM_W){imm[IMM_W-1]}}, imm};
				carry_in = 1'b1;
			end
			OP_MINUS: begin
				addend   = ALL_ONES;
				carry_in = carry_flag_ff;
			end
			default: begin
				addend   = WORD_RST;
				carry_in = 1'b0;
			end
		endcase
	end

	assign sum       = {1'b0, inv_a} + {1'b0, addend} + {{DATA_W{1'b0}}, carry_in};
	assign sum_word  = sum[DATA_W-1:0];
	assign carry_out = sum[DATA_W];
	// Signed overflow: like-signed addends giving an unlike-signed sum
	assign ovf = (inv_a[DATA_W-1] == addend[DATA_W-1]) &&
	             (sum_word[DATA_W-1] != inv_a[DATA_W-1]);

	// Register port decode
	assign flags_wr  = reg_wr && (reg_addr == FLAGS_ADDR);
	assign status_wr = reg_wr && (reg_addr == STATUS_ADDR);
	assign mask_wr   = reg_wr && (reg_addr == MASK_ADDR);

	// Software may clear summary overflow; an overflow in the same cycle still sets it
	assign cur_so = flags_wr ? reg_wdata[FLAG_SO] : summary_overflow_ff;
	assign nxt_so = (oe_form && ovf) ? 1'b1 : cur_so;

	// Carry flag: every executed form writes it
	always_ff @(posedge clk) begin
		if (reset) begin
			carry_flag_ff <= 1'b0;
		end else if (exec) begin
			carry_flag_ff <= carry_out;
		end else if (flags_wr) begin
			carry_flag_ff <= reg_wdata[FLAG_CARRY];
		end
	end

	// Overflow and summary overflow: only OE forms touch them
	always_ff @(posedge clk) begin
		if (reset) begin
			overflow_flag_ff    <= 1'b0;
			summary_overflow_ff <= 1'b0;
		end else begin
			if (oe_form) begin
				overflow_flag_ff <= ovf;
			end else if (flags_wr) begin
				overflow_flag_ff <= reg_wdata[FLAG_OVF];
			end
			summary_overflow_ff <= nxt_so;
		end
	end

	// Result to the register file
	always_ff @(posedge clk) begin
		if (reset) begin
			result_ff                <= WORD_RST;
			target_register_field_ff <= FIELD_RST;
			result_write_ff          <= 1'b0;
		end else begin
			result_write_ff <= exec;
			if (exec) begin
				result_ff                <= sum_word;
				target_register_field_ff <= instr[TGT_HI:TGT_LO];
			end
		end
	end

	// Condition field zero, written only by record forms
	always_ff @(posedge clk) begin
		if (reset) begin
			cr0_ff       <= CR_RST;
			cr0_write_ff <= 1'b0;
		end else begin
			cr0_write_ff <= record_bit;
			if (record_bit) begin
				cr0_ff[CR_NEG]  <= sum_word[DATA_W-1];
				cr0_ff[CR_POS]  <= !sum_word[DATA_W-1] && (sum_word != WORD_RST);
				cr0_ff[CR_ZERO] <= (sum_word == WORD_RST);
				cr0_ff[CR_SO]   <= nxt_so;
			end
		end
	end

	// Interrupt status: set wins over a write-one clear in the same cycle
	always_comb begin
		events             = '0;
		events[EV_OVF]     = oe_form && ovf;
		events[EV_DONE]    = exec;
		events[EV_ILLEGAL] = illegal;
		nxt_status = status_ff;
		if (status_wr) begin
			nxt_status = status_ff & ~reg_wdata[STATUS_W-1:0];
		end
		nxt_status = nxt_status | events;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff <= STATUS_RST;
		end else begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mask_ff <= MASK_RST;
		end else if (mask_wr) begin
			mask_ff <= reg_wdata[STATUS_W-1:0];
		end
	end

	// Registered from next values so the line tracks the status bits exactly
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else if (mask_wr) begin
			irq_ff <= |(nxt_status & reg_wdata[STATUS_W-1:0]);
		end else begin
			irq_ff <= |(nxt_status & mask_ff);
		end
	end

	// Read data one cycle after the strobe, zero otherwise and for unmapped addresses
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata_ff <= WORD_RST;
		end else begin
			reg_rdata_ff <= WORD_RST;
			if (reg_rd) begin
				if (reg_addr == FLAGS_ADDR) begin
					reg_rdata_ff[FLAGS_W-1:0] <= {summary_overflow_ff, overflow_flag_ff,
					                              carry_flag_ff};
				end else if (reg_addr == STATUS_ADDR) begin
					reg_rdata_ff[STATUS_W-1:0] <= status_ff;
				end else if (reg_addr == MASK_ADDR) begin
					reg_rdata_ff[STATUS_W-1:0] <= mask_ff;
				end else if (reg_addr == RESULT_ADDR) begin
					reg_rdata_ff <= result_ff;
				end
			end
		end
	end

	// Checks
	logic [DATA_W-1:0] chk_ext;
	logic [DATA_W-1:0] chk_minus;
	assign chk_ext   = inv_a + second_source_value + {{(DATA_W-1){1'b0}}, carry_flag_ff};
	assign chk_minus = inv_a + ALL_ONES + {{(DATA_W-1){1'b0}}, carry_flag_ff};

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_record_issue;
		exec && record_bit;
	endsequence

	sequence s_cr0_written;
		cr0_write_ff && (cr0_ff[CR_ZERO] == (result_ff == WORD_RST)) &&
		(cr0_ff[CR_NEG] == result_ff[DATA_W-1]) && (cr0_ff[CR_SO] == summary_overflow_ff);
	endsequence

	sequence s_imm_issue;
		instr_valid && (instr[OPC_HI:OPC_LO] == PRIMARY_IMM);
	endsequence

	a_ext_sum: assert property ((op == OP_EXT) |=> result_ff == $past(chk_ext))
		else $error("extended subtract result wrong");
	a_imm_decode: assert property (s_imm_issue |=> result_write_ff &&
		target_register_field_ff == $past(instr[TGT_HI:TGT_LO]))
		else $error("immediate form not executed");
	a_imm_sum: assert property (s_imm_issue |=> result_ff == ~$past(first_source_value) +
		{{(DATA_W-IMM_W){$past(imm[IMM_W-1])}}, $past(imm)} + 1'b1)
		else $error("immediate subtract result wrong");
	a_imm_inverse: assert property (s_imm_issue ##0 (imm == IMM_MINUS1) |=>
		result_ff == ~$past(first_source_value))
		else $error("minus one immediate not plain inverse");
	a_imm_no_cr0: assert property (s_imm_issue |=> !cr0_write_ff && $stable(cr0_ff))
		else $error("immediate form touched condition field");
	a_carry_always: assert property (exec |=> carry_flag_ff == $past(sum[DATA_W]))
		else $error("carry flag not updated");
	a_minus_sum: assert property ((op == OP_MINUS) |=> result_ff == $past(chk_minus))
		else $error("minus one extended result wrong");
	a_ovf_hold: assert property (!oe_form && !flags_wr |=> $stable(overflow_flag_ff))
		else $error("overflow changed without OE");
	a_ovf_set: assert property (oe_form && ovf |=> overflow_flag_ff && summary_overflow_ff)
		else $error("overflow not recorded");
	a_so_sticky: assert property (summary_overflow_ff && !flags_wr |=> summary_overflow_ff)
		else $error("summary overflow dropped");
	a_cr0_record: assert property (s_record_issue |=> s_cr0_written)
		else $error("condition field zero wrong");
	a_sign_ovf: assert property ((op == OP_EXT) && oe_form &&
		(inv_a[DATA_W-1] == second_source_value[DATA_W-1]) &&
		(chk_ext[DATA_W-1] != inv_a[DATA_W-1]) |=> overflow_flag_ff)
		else $error("signed overflow missed");
	a_forms_result: assert property (is_x_form |=> result_write_ff ##0
		(result_ff == $past(sum_word)))
		else $error("form changed result");
	a_irq_level: assert property (##1 irq_ff == |($past(nxt_status) & mask_ff) || $past(mask_wr))
		else $error("interrupt level wrong");

endmodule : subtract_from_carry_datapath

/* File: gpr_model.sv */
/*
 * Register-file and decoder model: presents an issued word with its source
 * values for one cycle and stores each written result by its target field.
 * Assumes the bench loads source registers directly between clock edges.
 */
`timescale 1ns/1ps

module gpr_model
	import subf_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                issue,
	input  wire logic [DATA_W-1:0]   word,
	input  wire logic [DATA_W-1:0]   result,
	input  wire logic [FIELD_W-1:0]  target,
	input  wire logic                result_write,
	output logic                     instr_valid,
	output logic      [DATA_W-1:0]   instr,
	output logic      [DATA_W-1:0]   first_source_value,
	output logic      [DATA_W-1:0]   second_source_value
);
	logic [DATA_W-1:0] gpr [32];

	// Idle lines toggle, so a design that samples them outside a valid cycle shows up
	always @(posedge clk) begin
		if (reset) begin
			instr_valid         <= 1'b0;
			instr               <= 32'h0;
			first_source_value  <= 32'h0;
			second_source_value <= 32'h0;
		end else begin
			instr_valid <= issue;
			instr       <= issue ? word : ~instr;
			if (issue) begin
				first_source_value  <= gpr[word[20:16]];
				second_source_value <= gpr[word[15:11]];
			end else begin
				first_source_value  <= ~first_source_value;
				second_source_value <= ~second_source_value;
			end
			if (result_write)
				gpr[target] <= result;
		end
	end
endmodule : gpr_model

/* File: tb_subtract_from_carry_datapath.sv */
/*
 * Self-checking bench for the subtract-from datapath: register port tasks,
 * instruction issue through the register-file model, flag prediction.
 * Assumes one 40 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module tb_subtract_from_carry_datapath
	import subf_pkg::*;
;
	logic               clk, reset, issue, reg_wr, reg_rd, instr_valid;
	logic [DATA_W-1:0]  word, reg_wdata, instr, first_source_value, second_source_value;
	logic [ADDR_W-1:0]  reg_addr;
	logic [DATA_W-1:0]  reg_rdata_ff, result_ff;
	logic [FIELD_W-1:0] target_register_field_ff;
	logic [CR_W-1:0]    cr0_ff, e_cr;
	logic               result_write_ff, cr0_write_ff, carry_flag_ff, overflow_flag_ff;
	logic               summary_overflow_ff, irq_ff, e_carry, e_ovf, e_so;
	logic [DATA_W-1:0]  r1, r2;
	int                 err_count, compares;

	subtract_from_carry_datapath i_subtract_from_carry_datapath (
		.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
		.first_source_value(first_source_value), .second_source_value(second_source_value),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .result_ff(result_ff),
		.target_register_field_ff(target_register_field_ff),
		.result_write_ff(result_write_ff), .cr0_ff(cr0_ff), .cr0_write_ff(cr0_write_ff),
		.carry_flag_ff(carry_flag_ff), .overflow_flag_ff(overflow_flag_ff),
		.summary_overflow_ff(summary_overflow_ff), .irq_ff(irq_ff));
	gpr_model i_gpr_model (.clk(clk), .reset(reset), .issue(issue), .word(word),
		.result(result_ff), .target(target_register_field_ff),
		.result_write(result_write_ff), .instr_valid(instr_valid), .instr(instr),
		.first_source_value(first_source_value), .second_source_value(second_source_value));

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata_ff, exp);
	endtask : rd

	task automatic setf(input logic [2:0] v);
		wr(FLAGS_ADDR, {29'h0, v});
		{e_so, e_ovf, e_carry} = v;
	endtask : setf

	// Reference arithmetic kept apart from the design: 33-bit sum, signed overflow
	function automatic logic [DATA_W-1:0] predict(input int kind, input logic oe, rec,
			input logic [DATA_W-1:0] a, b, input logic [15:0] imm);
		logic [DATA_W-1:0] x, y, s;
		logic              c, v;
		x = ~a;
		y = (kind == 0) ? b : (kind == 1) ? {{16{imm[15]}}, imm} : 32'hffffffff;
		{c, s} = {1'b0, x} + {1'b0, y} + ((kind == 1) ? 33'h1 : {32'h0, e_carry});
		v = (x[31] == y[31]) && (s[31] != x[31]);
		e_carry = c;
		if (kind != 1 && oe) begin
			e_ovf = v;
			e_so = e_so | v;
		end
		if (kind != 1 && rec)
			e_cr = {s[31], !s[31] && s != 32'h0, s == 32'h0, e_so};
		return s;
	endfunction : predict

	function automatic logic [DATA_W-1:0] enc(input int kind, input logic oe, rec,
			input logic [4:0] tgt, input logic [15:0] imm);
		case (kind)
			0: return {6'h1f, tgt, 5'h04, 5'h0a, oe, 9'h088, rec};
			1: return {6'h08, tgt, 5'h04, imm};
			default: return {6'h1f, tgt, 5'h04, 5'h1f, oe, 9'h0e8, rec};
		endcase
	endfunction : enc

	// Two words go out in consecutive cycles when two is set
	task automatic send(input logic [DATA_W-1:0] w1, w2, input bit two);
		@(posedge clk);
		issue <= 1'b1;
		word  <= w1;
		if (two) begin
			@(posedge clk);
			word <= w2;
		end
		@(posedge clk);
		issue <= 1'b0;
	endtask : send

	task automatic exec(input int kind, input logic oe, rec, input logic [DATA_W-1:0] a, b,
			input logic [15:0] imm, input logic [DATA_W-1:0] doc);
		logic [DATA_W-1:0] r;
		i_gpr_model.gpr[4]  = a;
		i_gpr_model.gpr[10] = b;
		r = predict(kind, oe, rec, a, b, imm);
		send(enc(kind, oe, rec, 5'h06, imm), 32'h0, 1'b0);
		@(posedge clk);
		#1;
		chk(result_ff, r);
		chk(result_ff, doc);
		chk(result_write_ff, 1'b1);
		chk(target_register_field_ff, 5'h06);
		chk(carry_flag_ff, e_carry);
		chk(overflow_flag_ff, e_ovf);
		chk(summary_overflow_ff, e_so);
		chk(cr0_write_ff, kind != 1 && rec);
		chk(cr0_ff, e_cr);
	endtask : exec

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end

	initial begin
		reset     = 1'b1;
		issue     = 1'b0;
		word      = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 32'h0;
		{e_so, e_ovf, e_carry} = 3'h0;
		e_cr      = 4'h0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(FLAGS_ADDR, 32'h0);
		rd(STATUS_ADDR, 32'h0);
		rd(MASK_ADDR, 32'h0);
		rd(RESULT_ADDR, 32'h0);
		rd(4'h2, 32'h0);
		chk(irq_ff, 1'b0);
		$display("test reset done");
		setf(3'h1);
		exec(0, 0, 0, 32'h90003000, 32'h80007000, 16'h0, 32'hf0004000);
		setf(3'h0);
		exec(0, 0, 1, 32'h00004500, 32'h80007000, 16'h0, 32'h80002aff);
		setf(3'h1);
		exec(0, 1, 0, 32'h80000000, 32'hefffffff, 16'h0, 32'h6fffffff);
		setf(3'h0);
		exec(0, 1, 1, 32'h80000000, 32'hefffffff, 16'h0, 32'h6ffffffe);
		setf(3'h1);
		exec(2, 0, 0, 32'h90003000, 32'h0, 16'h0, 32'h6fffcfff);
		setf(3'h0);
		exec(2, 0, 1, 32'hb0043000, 32'h0, 16'h0, 32'h4ffbcffe);
		setf(3'h1);
		exec(2, 1, 0, 32'hefffffff, 32'h0, 16'h0, 32'h10000000);
		setf(3'h0);
		exec(2, 1, 1, 32'hefffffff, 32'h0, 16'h0, 32'h0fffffff);
		exec(1, 0, 0, 32'h90003000, 32'h0, 16'h7000, 32'h70004000);
		$display("test forms done");
		setf(3'h6);
		exec(1, 0, 0, 32'h12345678, 32'h0, 16'hffff, 32'hedcba987);
		exec(1, 0, 0, 32'h0, 32'h0, 16'h0401, 32'h00000401);
		$display("test immediate done");
		setf(3'h0);
		exec(0, 1, 0, 32'h80000000, 32'h70000000, 16'h0, 32'hefffffff);
		exec(0, 1, 1, 32'h1, 32'h1, 16'h0, 32'hffffffff);
		exec(2, 0, 0, 32'h0, 32'h0, 16'h0, 32'hfffffffe);
		rd(STATUS_ADDR, 32'h3);
		rd(FLAGS_ADDR, {29'h0, e_so, e_ovf, e_carry});
		$display("test sticky done");
		setf(3'h0);
		i_gpr_model.gpr[4] = 32'h90003000;
		r1 = predict(2, 0, 0, 32'h90003000, 32'h0, 16'h0);
		r2 = predict(2, 1, 1, 32'h90003000, 32'h0, 16'h0);
		send(enc(2, 0, 0, 5'h07, 16'h0), enc(2, 1, 1, 5'h08, 16'h0), 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk(i_gpr_model.gpr[7], r1);
		chk(i_gpr_model.gpr[8], r2);
		chk(carry_flag_ff, e_carry);
		chk(cr0_ff, e_cr);
		$display("test back_to_back done");
		wr(STATUS_ADDR, 32'h7);
		send({6'h1f, 5'h06, 5'h04, 5'h00, 1'b0, 9'h0c8, 1'b0}, 32'h0, 1'b0);
		@(posedge clk);
		#1;
		chk(result_write_ff, 1'b0);
		chk(carry_flag_ff, e_carry);
		rd(STATUS_ADDR, 32'h4);
		$display("test illegal done");
		wr(STATUS_ADDR, 32'h7);
		wr(MASK_ADDR, 32'h2);
		rd(MASK_ADDR, 32'h2);
		exec(2, 0, 0, 32'h0, 32'h0, 16'h0, 32'hffffffff);
		@(posedge clk);
		#1;
		chk(irq_ff, 1'b1);
		rd(RESULT_ADDR, 32'hffffffff);
		wr(MASK_ADDR, 32'h0);
		@(posedge clk);
		#1;
		chk(irq_ff, 1'b0);
		wr(MASK_ADDR, 32'h2);
		wr(STATUS_ADDR, 32'h2);
		@(posedge clk);
		#1;
		chk(irq_ff, 1'b0);
		rd(STATUS_ADDR, 32'h0);
		$display("test interrupt done");
		conclude();
	end
endmodule : tb_subtract_from_carry_datapath
